// ---- rtl/pbr_bridge_core.sv ----
// bridge clocking, primary reset, port resets and primary decode
// assumes primary bus pins are sampled on clk_sys, the primary clock
// assumes bridge control reset bits arrive as levels from config logic
//
// How it works
// - upstream side runs on primary clock; downstream clock derived, up to 66 MHz
// - sixteen downstream clock outputs are copies of the primary clock
// - primary reset at once releases every upstream and downstream signal except port address, command and parity, which are driven low
// - primary reset returns every register to its default
// - primary reset may assert or release at any moment
// - accesses ignored during reset, refused for 2^25 clocks after release
// - port bus resets stay asserted while primary reset is asserted
// - software reset bit asserts port bus reset until the bit clears
// - port reset releases all port control signals and grants at once
// - port reset drives port address, command and parity low
// - port reset flushes posted-write and delayed-transaction buffers
// - software port reset keeps configuration access from upstream
// - interrupt acknowledge and special cycle never claimed
// - I/O commands claimed and forwarded only inside I/O window
// - memory commands claimed inside memory or memory-mapped I/O window
// - type 0 config with select claimed for implemented functions, served inside
// - type 1 config read forwarded as type 0, type 1, or ignored
// - config writes decoded as reads unless a special-cycle request
// - type 1 write to device 1Fh function 7h on the secondary bus becomes special cycle
`timescale 1ns/100ps
`include "pbr_defs.svh"

module pbr_bridge_core
  import pbr_pkg::*;
#(
  parameter int unsigned ACCESS_HOLD = `PBR_ACCESS_HOLD,
  parameter int unsigned NUM_CLK_OUT = `PBR_NUM_CLK_OUT,
  parameter int unsigned NUM_GNT = 8,
  parameter logic [7:0] IMPL_FUNCS = `PBR_IMPL_FUNCS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic [NUM_CLK_OUT-1:0] downstream_clock_outputs,
  // primary address phase
  input wire logic upstreamCmdValid,
  input wire logic [3:0] upstream_cmd_byte_en_n,
  input wire logic [31:0] upstreamAddr,
  input wire logic upstreamIdsel,
  input wire logic upstreamDriveReq,
  output logic upstreamOe_n,
  // decode windows and bus numbers
  input wire logic [31:0] ioBase,
  input wire logic [31:0] ioLimit,
  input wire logic [31:0] memBase,
  input wire logic [31:0] memLimit,
  input wire logic [31:0] mmioBase,
  input wire logic [31:0] mmioLimit,
  input wire logic [7:0] secBusNum,
  input wire logic [7:0] subBusNum,
  // decode answer
  output logic accessReady,
  output logic decodeValid,
  output logic decodeRefused,
  output logic decodeClaim,
  output logic decodeForward,
  output pbr_route_type decodeRoute,
  // port 1
  input wire logic port1SwReset,
  output logic port1_bus_reset_n,
  output logic port1Flush,
  input wire logic port1CtrlDriveReq,
  output logic port1CtrlOe_n,
  input wire logic [NUM_GNT-1:0] port1GrantReq,
  output logic [NUM_GNT-1:0] port1GrantOe_n,
  input wire logic port1AdDrive,
  input wire logic [31:0] port1AdSource,
  input wire logic [3:0] port1CbeSource,
  output logic [31:0] port1_addr_data,
  output logic [3:0] port1_cmd_byte_en_n,
  output logic port1_parity,
  output logic port1AdOe_n,
  // port 2
  input wire logic port2SwReset,
  output logic port2_bus_reset_n,
  output logic port2Flush,
  input wire logic port2CtrlDriveReq,
  output logic port2CtrlOe_n,
  input wire logic [NUM_GNT-1:0] port2GrantReq,
  output logic [NUM_GNT-1:0] port2GrantOe_n,
  input wire logic port2AdDrive,
  input wire logic [31:0] port2AdSource,
  input wire logic [3:0] port2CbeSource,
  output logic [31:0] port2_addr_data,
  output logic [3:0] port2_cmd_byte_en_n,
  output logic port2_parity,
  output logic port2AdOe_n
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // even parity over address/data and command lanes
  function automatic logic busParity(
    input logic [31:0] ad,
    input logic [3:0] cbe
  );
    busParity = ^{ad, cbe};
  endfunction : busParity

  // grant enables: all released while the port is in reset
  function automatic logic [NUM_GNT-1:0] grantEnables(
    input logic inReset,
    input logic [NUM_GNT-1:0] req
  );
    grantEnables = inReset ? {NUM_GNT{1'b1}} : ~req;
  endfunction : grantEnables

  ////////////////////////////////////////////////////////////////////////
  // clocking

  // the primary clock must stay within what the bridge supports
  localparam int unsigned CLK_MHZ = `PBR_CLK_MHZ;
  localparam int unsigned MAX_CLK_MHZ = `PBR_MAX_CLK_MHZ;
  localparam logic CLK_RATE_OK = (CLK_MHZ <= MAX_CLK_MHZ);

  // stand-in for the internal loop: zero-skew copies, one load each
  assign downstream_clock_outputs = {NUM_CLK_OUT{clk_sys & CLK_RATE_OK}};

  ////////////////////////////////////////////////////////////////////////
  // primary reset

  logic rstMeta_n;
  logic sysRst_n;

  // assertion passes at once; release is resynchronised to clk_sys
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      sysRst_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      sysRst_n <= rstMeta_n;
    end
  end

  // upstream pins released for the whole chip reset
  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      upstreamOe_n <= 1'b1;
    end else begin
      upstreamOe_n <= ~upstreamDriveReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access hold-off after release

  localparam logic [25:0] HOLD_LAST = 26'(ACCESS_HOLD - 1);

  pbr_access_type accState;
  logic [25:0] holdCount;

  // long wait: a simulation may shorten it through the parameter
  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      accState <= PBR_ACC_WAIT;
    end else begin
      unique case (accState)
        PBR_ACC_WAIT: begin
          if (holdCount == HOLD_LAST) accState <= PBR_ACC_READY;
        end
        PBR_ACC_READY: begin
          accState <= PBR_ACC_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      holdCount <= 26'h0000000;
    end else if (accState == PBR_ACC_WAIT) begin
      holdCount <= holdCount + 26'h0000001;
    end
  end

  assign accessReady = (accState == PBR_ACC_READY);

  ////////////////////////////////////////////////////////////////////////
  // primary command decode

  pbr_route_type next_route;
  logic routeForward;

  pbr_cmd_decode #(
    .IMPL_FUNCS(IMPL_FUNCS)
  ) u_decode (
    .cmd(upstream_cmd_byte_en_n),
    .addr(upstreamAddr),
    .idsel(upstreamIdsel),
    .ioBase(ioBase),
    .ioLimit(ioLimit),
    .memBase(memBase),
    .memLimit(memLimit),
    .mmioBase(mmioBase),
    .mmioLimit(mmioLimit),
    .secBusNum(secBusNum),
    .subBusNum(subBusNum),
    .route(next_route)
  );

  // internal accesses are served here and never passed on
  assign routeForward = (next_route != PBR_ROUTE_NONE) &&
                        (next_route != PBR_ROUTE_INTERNAL);

  // port software resets do not gate the decode, so config stays open
  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      decodeValid <= 1'b0;
      decodeRefused <= 1'b0;
      decodeClaim <= 1'b0;
      decodeForward <= 1'b0;
      decodeRoute <= PBR_ROUTE_NONE;
    end else begin
      decodeValid <= upstreamCmdValid && accessReady;
      decodeRefused <= upstreamCmdValid && !accessReady;
      if (upstreamCmdValid && accessReady) begin
        decodeClaim <= (next_route != PBR_ROUTE_NONE);
        decodeForward <= routeForward;
        decodeRoute <= next_route;
      end else begin
        decodeClaim <= 1'b0;
        decodeForward <= 1'b0;
        decodeRoute <= PBR_ROUTE_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port 1 reset and pin control

  logic port1InReset;

  // held low through chip reset; afterwards follows the control bit
  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      port1_bus_reset_n <= 1'b0;
    end else begin
      port1_bus_reset_n <= ~port1SwReset;
    end
  end

  assign port1InReset = ~port1_bus_reset_n;

  // buffer logic discards everything while this level is high
  assign port1Flush = port1InReset;

  assign port1CtrlOe_n = port1InReset | ~port1CtrlDriveReq;
  assign port1GrantOe_n = grantEnables(port1InReset, port1GrantReq);

  // lines stay driven while in reset so they do not float
  assign port1AdOe_n = port1InReset ? 1'b0 : ~port1AdDrive;

  // cleared on the same edge that asserts the port reset
  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      port1_addr_data <= 32'h00000000;
      port1_cmd_byte_en_n <= 4'h0;
      port1_parity <= 1'b0;
    end else if (port1SwReset) begin
      port1_addr_data <= 32'h00000000;
      port1_cmd_byte_en_n <= 4'h0;
      port1_parity <= 1'b0;
    end else begin
      port1_addr_data <= port1AdSource;
      port1_cmd_byte_en_n <= port1CbeSource;
      port1_parity <= busParity(port1AdSource, port1CbeSource);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port 2 reset and pin control

  logic port2InReset;

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      port2_bus_reset_n <= 1'b0;
    end else begin
      port2_bus_reset_n <= ~port2SwReset;
    end
  end

  assign port2InReset = ~port2_bus_reset_n;

  assign port2Flush = port2InReset;

  assign port2CtrlOe_n = port2InReset | ~port2CtrlDriveReq;
  assign port2GrantOe_n = grantEnables(port2InReset, port2GrantReq);

  assign port2AdOe_n = port2InReset ? 1'b0 : ~port2AdDrive;

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      port2_addr_data <= 32'h00000000;
      port2_cmd_byte_en_n <= 4'h0;
      port2_parity <= 1'b0;
    end else if (port2SwReset) begin
      port2_addr_data <= 32'h00000000;
      port2_cmd_byte_en_n <= 4'h0;
      port2_parity <= 1'b0;
    end else begin
      port2_addr_data <= port2AdSource;
      port2_cmd_byte_en_n <= port2CbeSource;
      port2_parity <= busParity(port2AdSource, port2CbeSource);
    end
  end

endmodule : pbr_bridge_core

// ---- rtl/pbr_cmd_decode.sv ----
// combinational claim or forward decision for one primary command
// assumes address-phase fields that are stable in the sampling cycle
`timescale 1ns/100ps
`include "pbr_defs.svh"

module pbr_cmd_decode
  import pbr_pkg::*;
#(
  parameter logic [7:0] IMPL_FUNCS = `PBR_IMPL_FUNCS
) (
  input wire logic [3:0] cmd,
  input wire logic [31:0] addr,
  input wire logic idsel,
  input wire logic [31:0] ioBase,
  input wire logic [31:0] ioLimit,
  input wire logic [31:0] memBase,
  input wire logic [31:0] memLimit,
  input wire logic [31:0] mmioBase,
  input wire logic [31:0] mmioLimit,
  input wire logic [7:0] secBusNum,
  input wire logic [7:0] subBusNum,
  output pbr_route_type route
);

  function automatic logic inRange(
    input logic [31:0] val,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    inRange = (val >= lo) && (val <= hi);
  endfunction : inRange

  logic [1:0] cfgType;
  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] func;
  logic behindBus;
  logic memHit;

  assign cfgType = addr[`PBR_CFG_TYPE_LSB +: 2];
  assign bus = addr[`PBR_CFG_BUS_LSB +: 8];
  assign dev = addr[`PBR_CFG_DEV_LSB +: 5];
  assign func = addr[`PBR_CFG_FUNC_LSB +: 3];
  assign behindBus = (bus > secBusNum) && (bus <= subBusNum);
  assign memHit = inRange(addr, memBase, memLimit) ||
                  inRange(addr, mmioBase, mmioLimit);

  always_comb begin
    route = PBR_ROUTE_NONE;
    unique case (cmd)
      `PBR_CMD_IO_RD, `PBR_CMD_IO_WR: begin
        if (inRange(addr, ioBase, ioLimit)) route = PBR_ROUTE_PASS;
      end
      `PBR_CMD_MEM_RD, `PBR_CMD_MEM_WR, `PBR_CMD_MEM_RDM,
      `PBR_CMD_MEM_RDL, `PBR_CMD_MEM_WRI: begin
        if (memHit) route = PBR_ROUTE_PASS;
      end
      `PBR_CMD_CFG_RD, `PBR_CMD_CFG_WR: begin
        if (cfgType == `PBR_CFG_TYPE0) begin
          if (idsel && IMPL_FUNCS[func]) route = PBR_ROUTE_INTERNAL;
        end else if (cfgType == `PBR_CFG_TYPE1) begin
          if (cmd == `PBR_CMD_CFG_WR && dev == `PBR_SPECIAL_DEV &&
              func == `PBR_SPECIAL_FUNC) begin
            if (bus == secBusNum) route = PBR_ROUTE_SPECIAL;
            else if (behindBus) route = PBR_ROUTE_TYPE1;
          end else if (bus == secBusNum) begin
            route = PBR_ROUTE_TYPE0;
          end else if (behindBus) begin
            route = PBR_ROUTE_TYPE1;
          end
        end
      end
      // interrupt acknowledge, special cycle, dual address and reserved stay unclaimed
      default: route = PBR_ROUTE_NONE;
    endcase
  end

endmodule : pbr_cmd_decode

// ---- rtl/pbr_defs.svh ----
// constants for the bridge reset and primary command decode
// assumes inclusion by bare name from the bridge package and modules
`ifndef PBR_DEFS_SVH
`define PBR_DEFS_SVH

// primary bus command codes
`define PBR_CMD_INTACK 4'h0
`define PBR_CMD_SPECIAL 4'h1
`define PBR_CMD_IO_RD 4'h2
`define PBR_CMD_IO_WR 4'h3
`define PBR_CMD_MEM_RD 4'h6
`define PBR_CMD_MEM_WR 4'h7
`define PBR_CMD_CFG_RD 4'ha
`define PBR_CMD_CFG_WR 4'hb
`define PBR_CMD_MEM_RDM 4'hc
`define PBR_CMD_DAC 4'hd
`define PBR_CMD_MEM_RDL 4'he
`define PBR_CMD_MEM_WRI 4'hf

// configuration address fields
`define PBR_CFG_TYPE_LSB 0
`define PBR_CFG_TYPE0 2'h0
`define PBR_CFG_TYPE1 2'h1
`define PBR_CFG_FUNC_LSB 8
`define PBR_CFG_DEV_LSB 11
`define PBR_CFG_BUS_LSB 16
`define PBR_SPECIAL_DEV 5'h1f
`define PBR_SPECIAL_FUNC 3'h7
`define PBR_IMPL_FUNCS 8'h03

// clocking and reset timing
`define PBR_MAX_CLK_MHZ 66
`define PBR_CLK_MHZ 20
`define PBR_ACCESS_HOLD 33554432
`define PBR_NUM_CLK_OUT 16

`endif

// ---- rtl/pbr_pkg.sv ----
// types shared by the bridge core and its command decoder
// assumes the defs header sits beside it on the include path
package pbr_pkg;

  typedef enum logic [2:0] {
    PBR_ROUTE_NONE,
    PBR_ROUTE_INTERNAL,
    PBR_ROUTE_PASS,
    PBR_ROUTE_TYPE0,
    PBR_ROUTE_TYPE1,
    PBR_ROUTE_SPECIAL
  } pbr_route_type;

  typedef enum {
    PBR_ACC_WAIT,
    PBR_ACC_READY
  } pbr_access_type;

endpackage : pbr_pkg

// ---- verification/pbr_bridge_core_props.sv ----
// checker for the bridge reset and primary decode ports
// assumes binding onto pbr_bridge_core, one clock domain
`timescale 1ns/100ps
module pbr_bridge_core_props
  import pbr_pkg::*;
#(
  parameter int unsigned ACCESS_HOLD = 16,
  parameter int unsigned NUM_GNT = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic upstreamCmdValid,
  input wire logic [3:0] upstream_cmd_byte_en_n,
  input wire logic accessReady,
  input wire logic decodeValid,
  input wire logic decodeRefused,
  input wire logic decodeClaim,
  input wire logic decodeForward,
  input wire pbr_route_type decodeRoute,
  input wire logic port1SwReset,
  input wire logic port1_bus_reset_n,
  input wire logic port1Flush,
  input wire logic port1CtrlOe_n,
  input wire logic [NUM_GNT-1:0] port1GrantOe_n,
  input wire logic [31:0] port1_addr_data,
  input wire logic [3:0] port1_cmd_byte_en_n,
  input wire logic port1_parity,
  input wire logic port2SwReset,
  input wire logic port2_bus_reset_n,
  input wire logic port2Flush
);
  int unsigned upCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // saturates past the hold-off so the late check fires exactly once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upCnt <= 0;
    end else if (upCnt < ACCESS_HOLD + 8) begin
      upCnt <= upCnt + 1;
    end
  end
  sequence swEnd(logic sw);
    sw ##1 !sw;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  early_refuse_a: assert property (upstreamCmdValid && !accessReady |=> decodeRefused && !decodeValid)
    else $error("command before hold-off not refused");
  ready_answer_a: assert property (upstreamCmdValid && accessReady |=> decodeValid && !decodeRefused)
    else $error("command after hold-off not answered");
  ready_early_a: assert property ($rose(accessReady) |-> upCnt >= ACCESS_HOLD)
    else $error("access ready before hold-off ran out");
  ready_late_a: assert property (upCnt == ACCESS_HOLD + 4 |-> accessReady)
    else $error("access ready late");
  ready_sticky_a: assert property (accessReady |=> accessReady)
    else $error("access ready dropped");
  idle_quiet_a: assert property (!upstreamCmdValid |=> !decodeValid && !decodeRefused)
    else $error("answer without command");
  claim_match_a: assert property (decodeValid |-> decodeClaim == (decodeRoute != PBR_ROUTE_NONE))
    else $error("claim disagrees with route");
  fwd_match_a: assert property (decodeValid |-> decodeForward == (decodeRoute > PBR_ROUTE_INTERNAL))
    else $error("forward disagrees with route");
  null_cmd_a: assert property (upstreamCmdValid && upstream_cmd_byte_en_n[3:1] == 3'h0 |=> !decodeClaim)
    else $error("intack or special cycle claimed");
  port_hold_a: assert property (port1SwReset |=> !port1_bus_reset_n && port1Flush)
    else $error("port 1 reset not applied");
  port2_hold_a: assert property (port2SwReset |=> !port2_bus_reset_n && port2Flush)
    else $error("port 2 reset not applied");
  port_quiet_a: assert property (!port1_bus_reset_n |-> port1CtrlOe_n && &port1GrantOe_n
      && port1_addr_data == 32'h0 && port1_cmd_byte_en_n == 4'h0 && !port1_parity)
    else $error("port 1 not quiet in reset");
  port_release_a: assert property (swEnd(port1SwReset) |-> ##[0:2] port1_bus_reset_n)
    else $error("port 1 reset not released");
endmodule : pbr_bridge_core_props

bind pbr_bridge_core pbr_bridge_core_props #(.ACCESS_HOLD(ACCESS_HOLD), .NUM_GNT(NUM_GNT)) props_u (
  .clk_sys, .reset_n, .upstreamCmdValid, .upstream_cmd_byte_en_n, .accessReady, .decodeValid,
  .decodeRefused, .decodeClaim, .decodeForward, .decodeRoute, .port1SwReset, .port1_bus_reset_n,
  .port1Flush, .port1CtrlOe_n, .port1GrantOe_n, .port1_addr_data, .port1_cmd_byte_en_n,
  .port1_parity, .port2SwReset, .port2_bus_reset_n, .port2Flush
);

// ---- verification/pbr_bridge_core_test.sv ----
// self-checking bench for the bridge reset and primary decode
// assumes the host model sits on the primary address phase
`timescale 1ns/100ps
module pbr_bridge_core_test;
  import pbr_pkg::*;
  localparam int HOLD = 16;
  localparam logic [48:0] RV = {3'b011, 8'hff, 38'h0};
  logic clk_sys, reset_n, upstreamCmdValid, upstreamIdsel, upstreamDriveReq, upstreamOe_n;
  logic [15:0] downstream_clock_outputs;
  logic [3:0] upstream_cmd_byte_en_n, port1CbeSource, port2CbeSource;
  logic [31:0] upstreamAddr, ioBase, ioLimit, memBase, memLimit, mmioBase, mmioLimit;
  logic [7:0] secBusNum, subBusNum, port1GrantReq, port2GrantReq, port1GrantOe_n, port2GrantOe_n;
  logic accessReady, decodeValid, decodeRefused, decodeClaim, decodeForward;
  pbr_route_type decodeRoute;
  logic port1SwReset, port1_bus_reset_n, port1Flush, port1CtrlDriveReq, port1CtrlOe_n;
  logic port1AdDrive, port1_parity, port1AdOe_n, port2AdDrive, port2_parity, port2AdOe_n;
  logic port2SwReset, port2_bus_reset_n, port2Flush, port2CtrlDriveReq, port2CtrlOe_n;
  logic [31:0] port1AdSource, port1_addr_data, port2AdSource, port2_addr_data;
  logic [3:0] port1_cmd_byte_en_n, port2_cmd_byte_en_n;
  int failures, nTests;

  always #25 clk_sys = ~clk_sys;

  pbr_host_model host_u (.clk_sys, .accessReady, .upstreamCmdValid, .upstream_cmd_byte_en_n,
    .upstreamAddr, .upstreamIdsel);
  pbr_bridge_core #(.ACCESS_HOLD(HOLD)) dut_u (
    .clk_sys, .reset_n, .downstream_clock_outputs, .upstreamCmdValid, .upstream_cmd_byte_en_n,
    .upstreamAddr, .upstreamIdsel, .upstreamDriveReq, .upstreamOe_n, .ioBase, .ioLimit, .memBase,
    .memLimit, .mmioBase, .mmioLimit, .secBusNum, .subBusNum, .accessReady, .decodeValid,
    .decodeRefused, .decodeClaim, .decodeForward, .decodeRoute, .port1SwReset, .port1_bus_reset_n,
    .port1Flush, .port1CtrlDriveReq, .port1CtrlOe_n, .port1GrantReq, .port1GrantOe_n,
    .port1AdDrive, .port1AdSource, .port1CbeSource, .port1_addr_data, .port1_cmd_byte_en_n,
    .port1_parity, .port1AdOe_n, .port2SwReset, .port2_bus_reset_n, .port2Flush,
    .port2CtrlDriveReq, .port2CtrlOe_n, .port2GrantReq, .port2GrantOe_n, .port2AdDrive,
    .port2AdSource, .port2CbeSource, .port2_addr_data, .port2_cmd_byte_en_n, .port2_parity,
    .port2AdOe_n);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkRoute(input pbr_route_type got, input pbr_route_type exp);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkRoute

  function automatic logic [48:0] pv(input int p);
    if (p == 1) begin
      return {port1_bus_reset_n, port1Flush, port1CtrlOe_n, port1GrantOe_n, port1AdOe_n,
        port1_parity, port1_cmd_byte_en_n, port1_addr_data};
    end
    return {port2_bus_reset_n, port2Flush, port2CtrlOe_n, port2GrantOe_n, port2AdOe_n,
      port2_parity, port2_cmd_byte_en_n, port2_addr_data};
  endfunction : pv

  // normal port state with both enables requested
  function automatic logic [48:0] nv(input int p);
    logic [31:0] a;
    logic [3:0] c;
    logic [7:0] g;
    a = (p == 1) ? 32'h1234_5678 : 32'h8765_4321;
    c = (p == 1) ? 4'ha : 4'h5;
    g = (p == 1) ? 8'h5a : 8'h3c;
    return {3'b100, ~g, 1'b0, ^{a, c}, c, a};
  endfunction : nv
  ////////////////////////////////////////////////////////////////////////////
  task automatic dec(input logic [3:0] c, input logic [31:0] a, input logic s, input pbr_route_type r);
    host_u.issue(c, a, s, 1'b0);
    #1;
    chk({decodeValid, decodeRefused, decodeClaim, decodeForward},
      {2'b10, r != PBR_ROUTE_NONE, r > PBR_ROUTE_INTERNAL});
    chkRoute(decodeRoute, r);
  endtask : dec

  task automatic t_hold;
    int n;
    n = 0;
    while (accessReady !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, HOLD + 2);
    chk(downstream_clock_outputs, {16{clk_sys}});
    chk(upstreamOe_n, 1'b0);
    $display("t_hold done");
  endtask : t_hold

  task automatic t_decode;
    logic [3:0] rsv[5] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hd};
    dec(4'h0, 32'h8000_0000, 1'b1, PBR_ROUTE_NONE);
    dec(4'h1, 32'h8000_0000, 1'b1, PBR_ROUTE_NONE);
    dec(4'h2, 32'h0000_1000, 1'b0, PBR_ROUTE_PASS);
    dec(4'h3, 32'h0000_1fff, 1'b0, PBR_ROUTE_PASS);
    dec(4'h3, 32'h0000_2000, 1'b0, PBR_ROUTE_NONE);
    dec(4'h6, 32'h8fff_fffc, 1'b0, PBR_ROUTE_PASS);
    dec(4'h7, 32'h90ff_fff0, 1'b0, PBR_ROUTE_PASS);
    dec(4'h6, 32'h7fff_fffc, 1'b0, PBR_ROUTE_NONE);
    dec(4'hc, 32'h8000_0040, 1'b0, PBR_ROUTE_PASS);
    foreach (rsv[i]) dec(rsv[i], 32'h8000_0000, 1'b1, PBR_ROUTE_NONE);
    dec(4'ha, 32'h0000_0100, 1'b1, PBR_ROUTE_INTERNAL);
    dec(4'ha, 32'h0000_0200, 1'b1, PBR_ROUTE_NONE);
    dec(4'ha, 32'h0000_0000, 1'b0, PBR_ROUTE_NONE);
    dec(4'ha, 32'h0002_0801, 1'b0, PBR_ROUTE_TYPE0);
    dec(4'ha, 32'h0005_0001, 1'b0, PBR_ROUTE_TYPE1);
    dec(4'ha, 32'h0006_0001, 1'b0, PBR_ROUTE_NONE);
    dec(4'hb, 32'h0000_0000, 1'b1, PBR_ROUTE_INTERNAL);
    dec(4'hb, 32'h0002_0001, 1'b0, PBR_ROUTE_TYPE0);
    dec(4'hb, 32'h0003_0001, 1'b0, PBR_ROUTE_TYPE1);
    dec(4'hb, 32'h0002_ff01, 1'b0, PBR_ROUTE_SPECIAL);
    dec(4'hb, 32'h0005_ff01, 1'b0, PBR_ROUTE_TYPE1);
    dec(4'hb, 32'h0009_ff01, 1'b0, PBR_ROUTE_NONE);
    dec(4'ha, 32'h0002_ff01, 1'b0, PBR_ROUTE_TYPE0);
    $display("t_decode done");
  endtask : t_decode

  task automatic t_port(input int p);
    @(posedge clk_sys);
    port1SwReset <= (p == 1);
    port2SwReset <= (p == 2);
    @(posedge clk_sys);
    #1;
    chk(pv(p), RV);
    chk(pv(3 - p), nv(3 - p));
    dec(4'ha, 32'h0000_0100, 1'b1, PBR_ROUTE_INTERNAL);
    chk(pv(p), RV);
    @(posedge clk_sys);
    port1SwReset <= 1'b0;
    port2SwReset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(pv(p), nv(p));
    $display("t_port %0d done", p);
  endtask : t_port

  task automatic t_reset;
    @(posedge clk_sys);
    #13;
    reset_n <= 1'b0;
    #1;
    chk(upstreamOe_n, 1'b1);
    chk(pv(1), RV);
    chk(pv(2), RV);
    chk({accessReady, decodeValid}, 2'b00);
    chk(downstream_clock_outputs, {16{clk_sys}});
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk(pv(1), RV);
    // internal reset still holds the decode for two edges after release
    repeat (2) @(posedge clk_sys);
    host_u.issue(4'ha, 32'h0000_0100, 1'b1, 1'b1);
    #1;
    chk({decodeRefused, decodeValid, decodeClaim}, 3'b100);
    dec(4'h6, 32'h8000_0000, 1'b0, PBR_ROUTE_PASS);
    $display("t_reset done");
  endtask : t_reset

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4000 * 50);
    failures++;
    test_done();
  end

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    failures = 0;
    nTests = 0;
    upstreamDriveReq = 1'b1;
    ioBase = 32'h0000_1000;
    ioLimit = 32'h0000_1fff;
    memBase = 32'h8000_0000;
    memLimit = 32'h8fff_ffff;
    mmioBase = 32'h9000_0000;
    mmioLimit = 32'h90ff_ffff;
    secBusNum = 8'h02;
    subBusNum = 8'h05;
    {port1SwReset, port2SwReset} = 2'b00;
    {port1CtrlDriveReq, port2CtrlDriveReq, port1AdDrive, port2AdDrive} = 4'hf;
    port1GrantReq = 8'h5a;
    port2GrantReq = 8'h3c;
    port1AdSource = 32'h1234_5678;
    port2AdSource = 32'h8765_4321;
    port1CbeSource = 4'ha;
    port2CbeSource = 4'h5;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_hold();
    t_decode();
    t_port(1);
    t_port(2);
    t_reset();
    test_done();
  end
endmodule : pbr_bridge_core_test

// ---- verification/pbr_host_model.sv ----
// upstream host model issuing one address phase at a time
// assumes the bench calls issue and judges the answer itself
`timescale 1ns/100ps
module pbr_host_model (
  input wire logic clk_sys,
  input wire logic accessReady,
  output logic upstreamCmdValid,
  output logic [3:0] upstream_cmd_byte_en_n,
  output logic [31:0] upstreamAddr,
  output logic upstreamIdsel
);
  initial begin
    upstreamCmdValid = 1'b0;
    upstream_cmd_byte_en_n = 4'hf;
    upstreamAddr = 32'h0;
    upstreamIdsel = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // early only when a scenario wants the refusal; a real host waits
  task automatic issue(input logic [3:0] c, input logic [31:0] a, input logic s, input bit early);
    int n;
    n = 0;
    while (!early && accessReady !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    upstreamCmdValid <= 1'b1;
    upstream_cmd_byte_en_n <= c;
    upstreamAddr <= a;
    upstreamIdsel <= s;
    @(posedge clk_sys);
    upstreamCmdValid <= 1'b0;
    // released lines must not keep the old value
    upstream_cmd_byte_en_n <= ~c;
    upstreamAddr <= ~a;
    upstreamIdsel <= ~s;
  endtask : issue
endmodule : pbr_host_model
